/* File: verilog/pld_macrocell_mode_config.sv */
// Eight-macrocell output block with three architecture modes and a sleep pin.
// Assumes the AND-array lives outside on ref_clk_i: it reads array_in_o and returns pterm_i.
// What this block does
// - Registered mode: pin 1 clock, pin 11 enable.
// - Complex mode: pins 1, 11 borrow outer feedback.
// - Simple mode: centre cells always-on outputs, no feedback.
// - Registered mode cells: registered, combinatorial or input.
// - Registered cell: enable pin, clock pin, eight terms.
// - Combinatorial cell: term enable, seven terms.
// - Input cell never drives its pin, except a centre cell in simple mode.
// - Complex mode: pins 13-18 feed back pin levels.
// - Complex mode: pins 12, 19 output only.
// - Complex mode: seven terms plus term enable.
// - Simple mode: eight terms, no term enable.
// - Simple mode: other cells input or output.
// - Complex and simple: pins 1, 11 are inputs.
// - Sleep option removes pin 4 from array.
// - Sleeping holds outputs, state, ignores inputs.
// - Registers clear low, registered pins read high.
`timescale 1ns/1ps
`include "pld_params.svh"

module pld_macrocell_mode_config
	import pld_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire arch_mode_t macrocell_architecture_mode_i,
	input wire cell_cfg_t [`CELL_COUNT-1:0] cell_cfg_i,
	input wire logic sleep_enable_i,
	input wire logic clk_pin_i,
	input wire logic oe_n_pin_i,
	input wire logic [`INPUT_PINS-1:0] dedicated_pin_i,
	input wire logic [`CELL_COUNT-1:0] io_pin_i,
	output logic [`CELL_COUNT-1:0] io_pin_o,
	output logic [`CELL_COUNT-1:0] io_pin_oe_n_o,
	output logic [`ARRAY_COLS-1:0] array_in_o,
	input wire logic [`CELL_COUNT-1:0][`PT_PER_CELL-1:0] pterm_i,
	output logic asleep_o
);

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	pin_sample_t sync1;
	pin_sample_t sampled;
	pin_sample_t next_sync1;
	pin_sample_t next_sampled;

	always_comb begin
		next_sync1.clk = clk_pin_i;
		next_sync1.oe_n = oe_n_pin_i;
		next_sync1.dedicated = dedicated_pin_i;
		next_sync1.io = io_pin_i;
		next_sampled = sync1;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= '0;
			sampled <= '0;
		end else begin
			sync1 <= next_sync1;
			sampled <= next_sampled;
		end
	end

	// ------------------------------------------------------------------------
	// Sleep control
	// ------------------------------------------------------------------------
	sleep_state_t state;
	sleep_state_t next_state;
	logic sleep_control_pin;
	logic hold;

	assign sleep_control_pin = sampled.dedicated[`SLEEP_PIN_INDEX];
	assign hold = (state == ST_ASLEEP);
	assign asleep_o = hold;

	always_comb begin
		next_state = state;
		case (state)
			ST_AWAKE: begin
				if (sleep_enable_i && sleep_control_pin) begin
					next_state = ST_ASLEEP;
				end
			end
			ST_ASLEEP: begin
				if (!(sleep_enable_i && sleep_control_pin)) begin
					next_state = ST_AWAKE;
				end
			end
			default: begin
				next_state = ST_AWAKE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_AWAKE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------------
	// Common clock edge
	// ------------------------------------------------------------------------
	// The previous level keeps tracking while asleep, so an edge seen during sleep is dropped, not deferred.
	logic clk_prev;
	logic next_clk_prev;
	logic capture;
	logic registered_mode;

	assign registered_mode = (macrocell_architecture_mode_i == MODE_REGISTERED);
	assign capture = sampled.clk && !clk_prev && !hold && registered_mode;

	always_comb begin
		next_clk_prev = sampled.clk;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= next_clk_prev;
		end
	end

	// ------------------------------------------------------------------------
	// Macrocells
	// ------------------------------------------------------------------------
	logic [`CELL_COUNT-1:0] cell_data;
	logic [`CELL_COUNT-1:0] cell_oe_n;
	logic [`CELL_COUNT-1:0] cell_q;

	genvar c;
	generate
		for (c = 0; c < `CELL_COUNT; c = c + 1) begin : g_cell
			pld_macrocell #(
				.CENTRE((c == `CENTRE_LO_CELL) || (c == `CENTRE_HI_CELL))
			) u_cell (
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.mode_i(macrocell_architecture_mode_i),
				.cfg_i(cell_cfg_i[c]),
				.pterm_i(pterm_i[c]),
				.capture_i(capture),
				.oe_pin_n_i(sampled.oe_n),
				.data_o(cell_data[c]),
				.oe_n_o(cell_oe_n[c]),
				.q_o(cell_q[c])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Array input routing
	// ------------------------------------------------------------------------
	logic [`ARRAY_COLS-1:0] next_array_in;

	always_comb begin
		next_array_in = array_in_o;
		if (!hold) begin
			next_array_in[`INPUT_PINS-1:0] = sampled.dedicated;
			if (sleep_enable_i) begin
				next_array_in[`SLEEP_PIN_INDEX] = 1'b0;
			end
			for (int i = 0; i < `CELL_COUNT; i++) begin
				next_array_in[`FB_COL_BASE+i] = sampled.io[i];
				case (macrocell_architecture_mode_i)
					MODE_COMPLEX: begin
						if (i == `OUTER_HI_CELL) begin
							next_array_in[`FB_COL_BASE+i] = sampled.clk;
						end else if (i == `OUTER_LO_CELL) begin
							next_array_in[`FB_COL_BASE+i] = sampled.oe_n;
						end
					end
					MODE_SIMPLE: begin
						if (i == `CENTRE_HI_CELL) begin
							next_array_in[`FB_COL_BASE+i] = sampled.clk;
						end else if (i == `CENTRE_LO_CELL) begin
							next_array_in[`FB_COL_BASE+i] = sampled.oe_n;
						end
					end
					default: begin
						if (cell_cfg_i[i].kind == CELL_REG) begin
							next_array_in[`FB_COL_BASE+i] = cell_q[i];
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			array_in_o <= '0;
		end else begin
			array_in_o <= next_array_in;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	logic [`CELL_COUNT-1:0] next_io_pin;
	logic [`CELL_COUNT-1:0] next_io_oe_n;

	always_comb begin
		next_io_pin = io_pin_o;
		next_io_oe_n = io_pin_oe_n_o;
		if (!hold) begin
			next_io_pin = cell_data;
			next_io_oe_n = cell_oe_n;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_pin_o <= {`CELL_COUNT{`PIN_RESET_VALUE}};
			io_pin_oe_n_o <= {`CELL_COUNT{`OE_N_RESET_VALUE}};
		end else begin
			io_pin_o <= next_io_pin;
			io_pin_oe_n_o <= next_io_oe_n;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_sleep_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		hold |=> ($stable(io_pin_o) && $stable(io_pin_oe_n_o) && $stable(array_in_o));
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("outputs moved while asleep");

	property p_sleep_no_edge;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		hold |=> $stable(cell_q);
	endproperty
	a_sleep_no_edge: assert property (p_sleep_no_edge) else $error("register moved while asleep");

	property p_sleep_pin_removed;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(sleep_enable_i && !hold) |=> (array_in_o[`SLEEP_PIN_INDEX] == 1'b0);
	endproperty
	a_sleep_pin_removed: assert property (p_sleep_pin_removed) else $error("sleep pin reached the array");

	property p_complex_borrow;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(macrocell_architecture_mode_i == MODE_COMPLEX && !hold) |=>
			(array_in_o[`FB_COL_BASE+`OUTER_HI_CELL] == $past(sampled.clk)) &&
			(array_in_o[`FB_COL_BASE+`OUTER_LO_CELL] == $past(sampled.oe_n));
	endproperty
	a_complex_borrow: assert property (p_complex_borrow) else $error("pins 1 and 11 not on outer columns");

	property p_complex_inner_fb;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(macrocell_architecture_mode_i == MODE_COMPLEX && !hold) |=>
			(array_in_o[`FB_COL_BASE+`CENTRE_LO_CELL] == $past(sampled.io[`CENTRE_LO_CELL]));
	endproperty
	a_complex_inner_fb: assert property (p_complex_inner_fb) else $error("inner pin level not fed back");

	property p_simple_centre;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(macrocell_architecture_mode_i == MODE_SIMPLE && !hold) |=>
			(!io_pin_oe_n_o[`CENTRE_LO_CELL] && !io_pin_oe_n_o[`CENTRE_HI_CELL]);
	endproperty
	a_simple_centre: assert property (p_simple_centre) else $error("centre pin not driven");

	property p_reg_enable;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(registered_mode && cell_cfg_i[0].kind == CELL_REG && !hold) |=>
			(io_pin_oe_n_o[0] == $past(sampled.oe_n));
	endproperty
	a_reg_enable: assert property (p_reg_enable) else $error("registered pin ignores enable pin");

	property p_reg_out_inverted;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(registered_mode && cell_cfg_i[0].kind == CELL_REG && !hold) |=> (io_pin_o[0] == ~$past(cell_q[0]));
	endproperty
	a_reg_out_inverted: assert property (p_reg_out_inverted) else $error("registered pin not inverted register");

	// The expected sum is rebuilt from the terms, so a broken capture path cannot hide behind its own strobe.
	logic cell0_sum;
	assign cell0_sum = (|pterm_i[0]) ^ cell_cfg_i[0].invert;

	property p_edge_capture;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(registered_mode && !hold && sampled.clk && !clk_prev && cell_cfg_i[0].kind == CELL_REG) |=>
			(cell_q[0] == $past(cell0_sum));
	endproperty
	a_edge_capture: assert property (p_edge_capture) else $error("rising clock pin edge not captured");

endmodule

/* File: verilog/pld_params.svh */
// Constants shared by the macrocell array: counts, pin positions, reset values.
// Assumes it is included by bare name wherever these constants are used.
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------------------
`define CELL_COUNT 8
`define PT_PER_CELL 8
`define INPUT_PINS 8
`define ARRAY_COLS 16
`define FB_COL_BASE 8

// ----------------------------------------------------------------------------
// Pin positions (cell 0 is pin 12, cell 7 is pin 19)
// ----------------------------------------------------------------------------
`define SLEEP_PIN_INDEX 2
`define OUTER_LO_CELL 0
`define OUTER_HI_CELL 7
`define CENTRE_LO_CELL 3
`define CENTRE_HI_CELL 4
`define OE_TERM 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define REG_RESET_VALUE 1'b0
`define OE_N_RESET_VALUE 1'b1
`define PIN_RESET_VALUE 1'b0

`endif

/* File: verilog/pld_pkg.sv */
// Types shared by the macrocell array and its cells.
// Assumes pld_params.svh is on the include path.
`include "pld_params.svh"

package pld_pkg;

	// ------------------------------------------------------------------------
	// Modes and cell kinds
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_REGISTERED = 2'h0,
		MODE_COMPLEX = 2'h1,
		MODE_SIMPLE = 2'h2
	} arch_mode_t;

	typedef enum logic [1:0] {
		CELL_INPUT = 2'h0,
		CELL_COMB = 2'h1,
		CELL_REG = 2'h2
	} cell_kind_t;

	typedef struct packed {
		cell_kind_t kind;
		logic invert;
	} cell_cfg_t;

	// ------------------------------------------------------------------------
	// Synchronised pin levels and sleep states
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic clk;
		logic oe_n;
		logic [`INPUT_PINS-1:0] dedicated;
		logic [`CELL_COUNT-1:0] io;
	} pin_sample_t;

	typedef enum logic [1:0] {
		ST_AWAKE = 2'b01,
		ST_ASLEEP = 2'b10
	} sleep_state_t;

endpackage

/* File: verilog/pld_macrocell.sv */
// One output macrocell: sum term, register, output enable choice.
// Assumes synchronised pin levels and a one-cycle capture pulse from its parent.
`timescale 1ns/1ps
`include "pld_params.svh"

module pld_macrocell
	import pld_pkg::*;
#(
	parameter bit CENTRE = 1'b0
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire arch_mode_t mode_i,
	input wire cell_cfg_t cfg_i,
	input wire logic [`PT_PER_CELL-1:0] pterm_i,
	input wire logic capture_i,
	input wire logic oe_pin_n_i,
	output logic data_o,
	output logic oe_n_o,
	output logic q_o
);

	// ------------------------------------------------------------------------
	// Sum terms and output enable
	// ------------------------------------------------------------------------
	logic sum_full;
	logic sum_short;
	logic next_q;

	assign sum_full = (|pterm_i) ^ cfg_i.invert;
	assign sum_short = (|pterm_i[`PT_PER_CELL-1:`OE_TERM+1]) ^ cfg_i.invert;

	always_comb begin
		data_o = `PIN_RESET_VALUE;
		oe_n_o = `OE_N_RESET_VALUE;
		case (mode_i)
			MODE_COMPLEX: begin
				if (cfg_i.kind != CELL_INPUT) begin
					data_o = sum_short;
					oe_n_o = ~pterm_i[`OE_TERM];
				end
			end
			MODE_SIMPLE: begin
				if (CENTRE || cfg_i.kind != CELL_INPUT) begin
					data_o = sum_full;
					oe_n_o = 1'b0;
				end
			end
			default: begin
				case (cfg_i.kind)
					CELL_REG: begin
						// common enable pin
						// Registered pins show the inverted register, so a cleared register reads high.
						data_o = ~q_o;
						oe_n_o = oe_pin_n_i;
					end
					CELL_COMB: begin
						data_o = sum_short;
						oe_n_o = ~pterm_i[`OE_TERM];
					end
					default: begin
						oe_n_o = 1'b1;
					end
				endcase
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Register
	// ------------------------------------------------------------------------
	always_comb begin
		next_q = q_o;
		if (capture_i && mode_i == MODE_REGISTERED && cfg_i.kind == CELL_REG) begin
			next_q = sum_full;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= `REG_RESET_VALUE;
		end else begin
			q_o <= next_q;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_reg_capture;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(capture_i && mode_i == MODE_REGISTERED && cfg_i.kind == CELL_REG) |=> (q_o == $past(sum_full));
	endproperty
	a_reg_capture: assert property (p_reg_capture) else $error("register missed its capture");

	property p_reg_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(!capture_i) |=> $stable(q_o);
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("register changed without an edge");

	property p_complex_oe;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(mode_i == MODE_COMPLEX && cfg_i.kind != CELL_INPUT) |-> (oe_n_o == ~pterm_i[`OE_TERM]) && (data_o == sum_short);
	endproperty
	a_complex_oe: assert property (p_complex_oe) else $error("complex cell enable or sum wrong");

	property p_simple_drive;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(mode_i == MODE_SIMPLE && (CENTRE || cfg_i.kind != CELL_INPUT)) |-> (!oe_n_o && data_o == sum_full);
	endproperty
	a_simple_drive: assert property (p_simple_drive) else $error("simple cell not driving its sum");

	property p_input_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(cfg_i.kind == CELL_INPUT && !(mode_i == MODE_SIMPLE && CENTRE)) |-> oe_n_o;
	endproperty
	a_input_off: assert property (p_input_off) else $error("input cell drives its pin");

endmodule

/* File: verification/pld_board_model.sv */
// Board around the macrocell pins: resolves each I/O wire from device and board drivers.
// Assumes the bench drives a pin only while the device's cell is an input.
`timescale 1ns/1ps

module pld_board_model (
	input wire logic [7:0] dev_data_i,
	input wire logic [7:0] dev_oe_n_i,
	input wire logic [7:0] board_data_i,
	input wire logic [7:0] board_en_i,
	output logic [7:0] pin_o
);
	// ------------------------------------------------------------------------
	// Wire resolution with pin keeper
	// ------------------------------------------------------------------------
	// An undriven pin keeps its last level, as the pin keepers do.
	// Two drivers at once resolve to unknown, so a clash is never hidden.
	logic [7:0] keep = 8'h00;

	always @* begin
		for (int i = 0; i < 8; i++) begin
			if (!dev_oe_n_i[i] && board_en_i[i]) begin
				keep[i] = 1'bx;
			end else if (!dev_oe_n_i[i]) begin
				keep[i] = dev_data_i[i];
			end else if (board_en_i[i]) begin
				keep[i] = board_data_i[i];
			end
		end
	end

	assign pin_o = keep;
endmodule

/* File: verification/pld_macrocell_mode_config_tb.sv */
// Self-checking bench for the eight-macrocell block: modes, cell kinds, sleep.
// Assumes the package and parameter header are compiled first.
`timescale 1ns/1ps
`include "pld_params.svh"

module pld_macrocell_mode_config_tb
	import pld_pkg::*;
;
	// ------------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	arch_mode_t mode = MODE_REGISTERED;
	cell_cfg_t [7:0] cfg = {8{CELL_REG, 1'b0}};
	logic sleep_en = 1'b0;
	logic clk_pin = 1'b0;
	logic oe_n_pin = 1'b0;
	logic [7:0] ded = 8'h00;
	logic [7:0] board_data = 8'h00;
	logic [7:0] board_en = 8'h00;
	logic [7:0][7:0] pterm = '0;
	logic [7:0] io_in;
	logic [7:0] io_out;
	logic [7:0] io_oe_n;
	logic [15:0] arr;
	logic asleep;
	int fails = 0;
	int checks = 0;

	always #50 ref_clk = ~ref_clk;

	pld_macrocell_mode_config DUT (
		.ref_clk_i(ref_clk),
		.rst_n_i(rst_n),
		.macrocell_architecture_mode_i(mode),
		.cell_cfg_i(cfg),
		.sleep_enable_i(sleep_en),
		.clk_pin_i(clk_pin),
		.oe_n_pin_i(oe_n_pin),
		.dedicated_pin_i(ded),
		.io_pin_i(io_in),
		.io_pin_o(io_out),
		.io_pin_oe_n_o(io_oe_n),
		.array_in_o(arr),
		.pterm_i(pterm),
		.asleep_o(asleep)
	);

	pld_board_model board (
		.dev_data_i(io_out),
		.dev_oe_n_i(io_oe_n),
		.board_data_i(board_data),
		.board_en_i(board_en),
		.pin_o(io_in)
	);

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Covers the two-flop pin synchroniser plus the array register, with margin.
	task automatic settle();
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic set_cells(input cell_kind_t k, input logic [7:0] inv);
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			cfg[i] <= '{k, inv[i]};
		end
	endtask

	// Clock pin must stay at each level for at least three reference clocks.
	task automatic pulse_clk_pin();
		@(posedge ref_clk);
		clk_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		clk_pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic wait_asleep(input logic lvl);
		int n;
		n = 0;
		while (asleep !== lvl && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		if (asleep !== lvl) begin
			fails++;
			$display("CHECK FAILED asleep_o wait expected %b seen %b", lvl, asleep);
			print_verdict();
		end
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_reset();
		repeat (2) @(negedge ref_clk);
		check("oe_n in reset", io_oe_n, 8'hFF);
		check("asleep in reset", asleep, 1'b0);
		check("data in reset", io_out, 8'h00);
		check("array in reset", arr, 16'h0000);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		settle();
		check("cleared regs read high", io_out, 8'hFF);
		check("common enable drives", io_oe_n, 8'h00);
	endtask

	task automatic t_registered();
		@(posedge ref_clk);
		pterm <= {8'h00, 8'h02, 8'h00, 8'h10, 8'h00, 8'h80, 8'h00, 8'h01};
		settle();
		check("no capture without clock pin", io_out, 8'hFF);
		pulse_clk_pin();
		settle();
		check("captured pins", io_out, 8'hAA);
		check("reg feedback", arr[15:8], 8'h55);
		set_cells(CELL_REG, 8'hFF);
		pulse_clk_pin();
		settle();
		check("inverted capture", io_out, 8'h55);
		@(posedge ref_clk);
		oe_n_pin <= 1'b1;
		settle();
		check("enable pin off", io_oe_n, 8'hFF);
		@(posedge ref_clk);
		oe_n_pin <= 1'b0;
	endtask

	task automatic t_sleep();
		@(posedge ref_clk);
		sleep_en <= 1'b1;
		ded <= 8'h04;
		wait_asleep(1'b1);
		settle();
		check("sleep pin column", arr[7:0], 8'h00);
		@(posedge ref_clk);
		clk_pin <= 1'b1;
		oe_n_pin <= 1'b1;
		pterm <= '1;
		settle();
		check("frozen data", io_out, 8'h55);
		check("frozen enables", io_oe_n, 8'h00);
		@(posedge ref_clk);
		clk_pin <= 1'b0;
		ded <= 8'h00;
		wait_asleep(1'b0);
		settle();
		check("clock edge dropped", io_out, 8'h55);
		check("enable pin after wake", io_oe_n, 8'hFF);
		@(posedge ref_clk);
		oe_n_pin <= 1'b0;
		sleep_en <= 1'b0;
	endtask

	task automatic t_mixed();
		@(posedge ref_clk);
		cfg[0] <= '{CELL_COMB, 1'b0};
		cfg[1] <= '{CELL_INPUT, 1'b0};
		pterm[0] <= 8'h01;
		pterm[1] <= 8'hFF;
		ded <= 8'hA4;
		// The board waits until the cell's driver is off, so the two never fight over the pin.
		repeat (2) @(posedge ref_clk);
		board_en <= 8'h02;
		board_data <= 8'h02;
		settle();
		check("pin 4 as plain input", arr[7:0], 8'hA4);
		check("term enable and input off", io_oe_n[1:0], 2'b10);
		check("seven terms only", io_out[0], 1'b0);
		check("cell feedback", arr[9:8], 2'b10);
		@(posedge ref_clk);
		pterm[0] <= 8'h00;
		settle();
		check("term enable off", io_oe_n[0], 1'b1);
		@(posedge ref_clk);
		board_en <= 8'h00;
		ded <= 8'h00;
	endtask

	task automatic t_complex();
		@(posedge ref_clk);
		mode <= MODE_COMPLEX;
		pterm <= {8{8'h03}};
		clk_pin <= 1'b1;
		set_cells(CELL_COMB, 8'h80);
		settle();
		check("complex data", io_out, 8'h7F);
		check("complex enables", io_oe_n, 8'h00);
		check("complex columns", arr[15:8], 8'hFE);
		check("outer pin 12 no feedback", {arr[8], io_out[0]}, 2'b01);
		@(posedge ref_clk);
		clk_pin <= 1'b0;
		oe_n_pin <= 1'b1;
		settle();
		check("pins 1 and 11 as inputs", arr[15:8], 8'h7F);
	endtask

	task automatic t_simple();
		@(posedge ref_clk);
		mode <= MODE_SIMPLE;
		pterm <= {8{8'h01}};
		clk_pin <= 1'b1;
		oe_n_pin <= 1'b0;
		set_cells(CELL_INPUT, 8'h00);
		repeat (2) @(posedge ref_clk);
		board_en <= 8'hE7;
		settle();
		check("centre cells driven", io_oe_n, 8'hE7);
		check("eight terms", io_out[4:3], 2'b11);
		check("simple pin 1 and 11", arr[12:11], 2'b10);
		@(posedge ref_clk);
		board_en <= 8'h00;
		set_cells(CELL_COMB, 8'h00);
		settle();
		check("no term enable", io_oe_n, 8'h00);
		check("simple outputs", io_out, 8'hFF);
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_registered();
		t_sleep();
		t_mixed();
		t_complex();
		t_simple();
		print_verdict();
	end
endmodule
